// file: cgpm_cfg.svh
// Constants for the custom glyph pattern memory
`ifndef CGPM_CFG_SVH
`define CGPM_CFG_SVH
`define CGPM_DEPTH 64
`define CGPM_WIDTH 8
`define CGPM_ADDR_W 6
`define CGPM_COLS 5
`define CGPM_ROW_LSB 0
`define CGPM_ROW_W 3
`define CGPM_SLOT_LSB 3
`define CGPM_CURSOR_ROW 3'h7
`define CGPM_CUSTOM_HI 4'h0
`define CGPM_TALL_SLOT_W 2
`define CGPM_WORD_RST 8'h00
`define CGPM_PTR_RST 6'h00
`endif

// file: cgpm_pkg.sv
// Types shared by the custom glyph pattern memory files
`default_nettype none
package cgpm_pkg;
    // Host port activity
    typedef enum logic [2:0] {
        CGPM_IDLE = 3'b001,
        CGPM_WRITE = 3'b010,
        CGPM_READ = 3'b100
    } cgpm_op_type;
endpackage : cgpm_pkg
`default_nettype wire

// file: cgpm_store.sv
// Flip-flop storage of the custom glyph pattern memory
`timescale 1ns/10ps
`default_nettype none
`include "cgpm_cfg.svh"
module cgpm_store #(
    parameter int DEPTH = `CGPM_DEPTH,
    parameter int WIDTH = `CGPM_WIDTH,
    parameter int AW = `CGPM_ADDR_W
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // Host write port
    input wire logic i_wr_en,
    input wire logic [AW-1:0] i_wr_addr,
    input wire logic [WIDTH-1:0] i_wr_data,
    // Host read port
    input wire logic [AW-1:0] i_rd_addr,
    output logic [WIDTH-1:0] o_rd_data,
    // Display fetch port
    input wire logic [AW-1:0] i_fetch_addr,
    output logic [WIDTH-1:0] o_fetch_data
);
    logic [WIDTH-1:0] mem_r [DEPTH];

    // Refuse a depth that the address width cannot index exactly
    if (DEPTH != (1 << AW)) begin : gen_bad_depth
        $error("cgpm_store: DEPTH must equal 2**AW");
    end

    // All eight bits are kept, displayed or not
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_r[i] <= `CGPM_WORD_RST;
            end
        end else if (i_wr_en) begin
            mem_r[i_wr_addr] <= i_wr_data; // R1 R4 R14
        end
    end

    assign o_rd_data = mem_r[i_rd_addr];
    assign o_fetch_data = mem_r[i_fetch_addr];
endmodule : cgpm_store
`default_nettype wire

// file: cgpm_glyph_mem.sv
// Custom glyph pattern memory: host access and pixel row fetch
// Operation
// R1 - 64 words of 8 bits, host writable
// R2 - Eight 5x7 slots or four 5x10 slots; the tall font fetches only rows 0-7 of slots 0, 2, 4 and 6
// R3 - Codes 00H-07H show the custom glyphs
// R4 - Unused words stay general read/write storage
// R5 - Only low five bits reach display
// R6 - Pointer advances after each data write
// R7 - Host sets address, writes rows, returns
// R8 - Code bits 0-2 form address bits 3-5
// R9 - Address bits 0-2 pick the row
// R10 - Eighth row is ORed with cursor
// R11 - Stored one in row eight always lights
// R12 - Host keeps row eight zero for cursor
// R13 - Bits 0-4 are columns, bit 4 leftmost
// R14 - Bits 5-7 stored but not displayed
// R15 - Upper code nibble zero selects custom memory
// R16 - Code bit 3 ignored for selection
// R17 - Stored one selects pixel, zero does not
// R18 - Pointer steps by one on read or write
// R19 - Data write goes via holding register
// R20 - Host waits for pending flag clear
// R21 - Data reads return all eight bits
`timescale 1ns/10ps
`default_nettype none
`include "cgpm_cfg.svh"
module cgpm_glyph_mem #(
    parameter int DEPTH = `CGPM_DEPTH,
    parameter int WIDTH = `CGPM_WIDTH,
    parameter int AW = `CGPM_ADDR_W,
    parameter int COLS = `CGPM_COLS
) (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // Pointer load from the command path
    input wire logic i_ptr_load,
    input wire logic [AW-1:0] i_ptr_value,
    input wire logic i_entry_increment,
    // Data access through the holding register
    input wire logic i_data_write,
    input wire logic i_data_read,
    input wire logic [WIDTH-1:0] i_write_data,
    output logic [WIDTH-1:0] o_data_holding_reg,
    output logic [AW-1:0] o_address_pointer,
    output logic o_internal_op_pending,
    // Display fetch
    input wire logic i_tall_font,
    input wire logic [7:0] i_char_code,
    input wire logic [2:0] i_row,
    input wire logic i_cursor_here,
    output logic o_custom_select,
    output logic [COLS-1:0] o_pixels
);
    // Holding register, pointer, commit, access and display state
    logic [WIDTH-1:0] data_holding_reg_r;
    logic [WIDTH-1:0] data_holding_reg_nxt;
    logic [AW-1:0] address_pointer_r;
    logic [AW-1:0] address_pointer_nxt;
    logic pending_r;
    logic pending_nxt;
    logic [AW-1:0] wr_addr_r;
    logic [AW-1:0] wr_addr_nxt;
    logic [COLS-1:0] pixels_r;
    logic [COLS-1:0] pixels_nxt;
    logic custom_r;
    logic custom_nxt;
    cgpm_pkg::cgpm_op_type op_r;
    cgpm_pkg::cgpm_op_type op_nxt;

    // Decode wires
    logic [AW-1:0] fetch_addr;
    logic [AW-1:0] step_addr;
    logic [WIDTH-1:0] rd_word;
    logic [WIDTH-1:0] fetch_word;
    logic [COLS-1:0] row_bits;
    logic custom_sel;
    logic store_en;
    logic wr_take;
    logic rd_take;

    // Refuse geometries the stored word or the slot and row fold cannot serve
    // A wider address is allowed; the fold then uses the low words only
    if (COLS > WIDTH) begin : gen_bad_cols
        $error("cgpm_glyph_mem: COLS wider than a stored word");
    end
    if (AW < `CGPM_SLOT_LSB + `CGPM_ROW_W) begin : gen_bad_aw
        $error("cgpm_glyph_mem: address too narrow for slot and row");
    end

    // Pointer moves by exactly one in the entry direction
    function automatic logic [AW-1:0] step(input logic [AW-1:0] a,
                                           input logic up);
        step = up ? a + AW'(1) : a - AW'(1); // R18
    endfunction : step

    // Slot and row fold into an address; tall font uses only the even slot of each pair
    function automatic logic [AW-1:0] glyph_addr(input logic [7:0] code,
                                                 input logic [2:0] row,
                                                 input logic tall);
        logic [2:0] slot;
        slot = code[2:0]; // R8 R16
        if (tall) begin
            slot = {code[`CGPM_TALL_SLOT_W-1:0], 1'b0}; // R2
        end
        glyph_addr = AW'({slot, row}); // R9
    endfunction : glyph_addr

    // An access is taken only while no commit is pending
    assign wr_take = i_data_write && !pending_r; // R20
    assign rd_take = i_data_read && !pending_r;
    // Write has priority over read in the same cycle
    assign op_nxt = wr_take ? cgpm_pkg::CGPM_WRITE :
                    rd_take ? cgpm_pkg::CGPM_READ :
                    cgpm_pkg::CGPM_IDLE;
    assign step_addr = step(address_pointer_r, i_entry_increment);
    // Step the pointer only for an access that was taken
    assign address_pointer_nxt = i_ptr_load ? i_ptr_value :
                                 (op_nxt != cgpm_pkg::CGPM_IDLE) ?
                                 step_addr : address_pointer_r; // R6 R18
    // Outside a write, prefetch keeps the holding register showing the word at the pointer
    assign data_holding_reg_nxt = (op_nxt == cgpm_pkg::CGPM_WRITE) ?
                                  i_write_data : rd_word; // R19 R21
    assign store_en = (op_r == cgpm_pkg::CGPM_WRITE); // R19
    // Write address trails the pointer; the byte lands one edge later
    assign wr_addr_nxt = address_pointer_r;
    // Pending covers the commit cycle, so a second access waits
    assign pending_nxt = (op_nxt == cgpm_pkg::CGPM_WRITE); // R20

    // Display path selection
    assign custom_sel = (i_char_code[7:4] == `CGPM_CUSTOM_HI); // R3 R15
    assign fetch_addr = glyph_addr(i_char_code, i_row, i_tall_font);
    assign row_bits = fetch_word[COLS-1:0] |
                      {COLS{i_cursor_here &&
                            i_row == `CGPM_CURSOR_ROW}}; // R5 R10 R11
    // Fixed glyph codes give a dark row here; that path lies elsewhere
    assign pixels_nxt = custom_sel ? row_bits : {COLS{1'b0}}; // R13 R17
    assign custom_nxt = custom_sel; // R15

    // One write port for the host commit, two read ports; the host read
    // looks at the next pointer so the prefetch lands with the step

    cgpm_store #(
        .DEPTH(DEPTH),
        .WIDTH(WIDTH),
        .AW(AW)
    ) u_store (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_wr_en(store_en),
        .i_wr_addr(wr_addr_r),
        .i_wr_data(data_holding_reg_r),
        .i_rd_addr(address_pointer_nxt),
        .o_rd_data(rd_word),
        .i_fetch_addr(fetch_addr),
        .o_fetch_data(fetch_word)
    );

    // Holding register: captured byte on a write, else the prefetched word
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            data_holding_reg_r <= `CGPM_WORD_RST;
        end else begin
            data_holding_reg_r <= data_holding_reg_nxt; // R19 R21
        end
    end

    // Address pointer; a load from the command path wins over a step
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            address_pointer_r <= `CGPM_PTR_RST;
        end else begin
            address_pointer_r <= address_pointer_nxt; // R6 R18
        end
    end

    // Commit address, held for the edge at which the byte lands
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            wr_addr_r <= `CGPM_PTR_RST;
        end else begin
            wr_addr_r <= wr_addr_nxt;
        end
    end

    // Access state and the one-cycle pending flag
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            pending_r <= 1'b0;
            op_r <= cgpm_pkg::CGPM_IDLE;
        end else begin
            pending_r <= pending_nxt;
            op_r <= op_nxt;
        end
    end

    // Registered pixel row; ones select pixels, bit 4 leftmost
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            pixels_r <= {COLS{1'b0}};
        end else begin
            pixels_r <= pixels_nxt; // R13 R17
        end
    end

    // Custom select flag, aligned with the pixel row it qualifies
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            custom_r <= 1'b0;
        end else begin
            custom_r <= custom_nxt;
        end
    end

    assign o_data_holding_reg = data_holding_reg_r;
    assign o_address_pointer = address_pointer_r;
    assign o_internal_op_pending = pending_r;
    assign o_custom_select = custom_r;
    assign o_pixels = pixels_r;
endmodule : cgpm_glyph_mem
`default_nettype wire

// file: cgpm_glyph_mem_sva.sv
// Port checker for the custom glyph pattern memory
`timescale 1ns/10ps
`default_nettype none
module cgpm_glyph_mem_chk (
    // Clock and reset
    input wire logic i_clock,
    input wire logic i_rst,
    // Host side
    input wire logic i_ptr_load,
    input wire logic i_entry_increment,
    input wire logic i_data_write,
    input wire logic i_data_read,
    input wire logic o_internal_op_pending,
    input wire logic [5:0] i_ptr_value,
    input wire logic [5:0] o_address_pointer,
    input wire logic [7:0] i_write_data,
    input wire logic [7:0] o_data_holding_reg,
    // Display side
    input wire logic [7:0] i_char_code,
    input wire logic i_tall_font,
    input wire logic i_cursor_here,
    input wire logic o_custom_select,
    input wire logic [2:0] i_row,
    input wire logic [4:0] o_pixels
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_rst);
    // A load wins over a step, so only plain writes count as steps
    wire wr_ok = i_data_write && !o_internal_op_pending && !i_ptr_load;
    a_write_hold: assert property (wr_ok |=>
        o_data_holding_reg == $past(i_write_data)) else $error("hold bad");
    a_ptr_step: assert property (wr_ok |=> o_address_pointer ==
        $past(o_address_pointer) + ($past(i_entry_increment) ? 6'h01 : 6'h3F))
        else $error("step bad");
    a_op_pulse: assert property (wr_ok |=>
        o_internal_op_pending ##1 !o_internal_op_pending) else $error("busy");
    a_ptr_load: assert property (i_ptr_load |=>
        o_address_pointer == $past(i_ptr_value)) else $error("load bad");
    a_ptr_still: assert property (!i_ptr_load && !i_data_write &&
        !i_data_read |=> $stable(o_address_pointer)) else $error("drift");
    a_custom_sel: assert property (1'b1 |=>
        o_custom_select == ($past(i_char_code) < 8'h10)) else $error("sel");
    a_rom_dark: assert property (!o_custom_select |->
        o_pixels == 5'h00) else $error("dark");
    a_cursor_row: assert property (i_cursor_here && i_row == 3'h7 &&
        i_char_code < 8'h10 |=> o_pixels == 5'h1F) else $error("cursor");
endmodule : cgpm_glyph_mem_chk
bind cgpm_glyph_mem cgpm_glyph_mem_chk cgpm_glyph_mem_chk_inst (.*);
`default_nettype wire

// file: cgpm_host.sv
// Host processor model for the glyph memory data port
`timescale 1ns/10ps
`default_nettype none
module cgpm_host (
    // Clock and status
    input wire logic i_clock,
    input wire logic i_pending,
    // Requests
    output logic o_load, o_wr, o_rd, o_inc,
    output logic [5:0] o_addr,
    output logic [7:0] o_data
);
    initial {o_load, o_wr, o_rd, o_inc, o_addr, o_data} = '0;
    // One request: 0 read, 1 write, 2 pointer load; held one full cycle
    task automatic req(input int k, input logic [7:0] d, input logic up);
        @(negedge i_clock);
        while (i_pending) @(negedge i_clock);
        o_data = d;
        o_addr = d[5:0];
        o_inc = up;
        {o_load, o_wr, o_rd} = 3'h1 << k;
        @(negedge i_clock);
        {o_load, o_wr, o_rd} = 3'h0;
        o_data = ~d; // Released bus must not look like valid data
    endtask : req
endmodule : cgpm_host
`default_nettype wire

// file: test_custom_glyph_pattern_memory.sv
// Self-checking bench for the custom glyph pattern memory
`timescale 1ns/10ps
`default_nettype none
module test_custom_glyph_pattern_memory;
    logic i_clock = 0, i_rst = 1, i_tall_font = 0, i_cursor_here = 0;
    logic [7:0] i_char_code = 8'h00;
    logic [2:0] i_row = 3'h0;
    wire logic ld, wr, rd, up, busy, sel;
    wire logic [5:0] pv, ptr;
    wire logic [7:0] wd, hold;
    wire logic [4:0] pix;
    logic [7:0] mem [64];
    int num_errors = 0, total_checks = 0, seed = 82;
    initial forever #2.5 i_clock = ~i_clock;
    cgpm_host cgpm_host_inst (.i_clock(i_clock), .i_pending(busy),
        .o_load(ld), .o_wr(wr), .o_rd(rd), .o_inc(up), .o_addr(pv),
        .o_data(wd));
    cgpm_glyph_mem cgpm_glyph_mem_inst (.i_clock(i_clock), .i_rst(i_rst),
        .i_ptr_load(ld), .i_ptr_value(pv), .i_entry_increment(up),
        .i_data_write(wr), .i_data_read(rd), .i_write_data(wd),
        .o_data_holding_reg(hold), .o_address_pointer(ptr),
        .o_internal_op_pending(busy), .i_tall_font(i_tall_font),
        .i_char_code(i_char_code), .i_row(i_row),
        .i_cursor_here(i_cursor_here), .o_custom_select(sel),
        .o_pixels(pix));
    // Byte compare, narrower results are zero extended
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // Expected pixel row; tall font uses even slots only
    function automatic logic [4:0] pix_exp(input logic [7:0] c,
        input logic [2:0] r, input logic cur, input logic tall);
        logic [5:0] a;
        a = tall ? {c[1:0], 1'b0, r} : {c[2:0], r};
        if (c[7:4] != 4'h0) return 5'h00;
        return mem[a][4:0] | ((r == 3'h7 && cur) ? 5'h1F : 5'h00);
    endfunction : pix_exp
    task automatic conclude();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : conclude
    // Watchdog well beyond the expected thousand or so cycles
    initial begin
        #50000;
        num_errors++;
        conclude();
    end
    // Program, wrap, read back, then display
    initial begin
        foreach (mem[i]) mem[i] = 8'h00;
        repeat (12) @(negedge i_clock);
        i_rst = 0;
        chk({2'h0, ptr}, 8'h00);
        for (int s = 0; s < 8; s++) begin
            cgpm_host_inst.req(2, {2'h0, s[2:0], 3'h0}, 1'b1);
            for (int r = 0; r < 8; r++) begin
                logic [7:0] d;
                d = (r == 7 && s < 6) ? 8'h00 : 8'($random(seed));
                mem[{s[2:0], r[2:0]}] = d;
                cgpm_host_inst.req(1, d, 1'b1);
                chk(hold, d);
                chk({7'h0, busy}, 8'h01);
                chk({2'h0, ptr}, {2'h0, 6'({s[2:0], r[2:0]} + 6'h01)});
            end
        end
        $display("test program done");
        cgpm_host_inst.req(2, 8'h00, 1'b0);
        cgpm_host_inst.req(1, 8'hA5, 1'b0);
        mem[0] = 8'hA5;
        chk({2'h0, ptr}, 8'h3F);
        $display("test wrap done");
        cgpm_host_inst.req(2, 8'h00, 1'b1);
        @(negedge i_clock);
        chk(hold, mem[0]);
        for (int i = 1; i < 64; i++) begin
            cgpm_host_inst.req(0, 8'h00, 1'b1);
            @(negedge i_clock);
            chk(hold, mem[i]);
            chk({2'h0, ptr}, 8'(i));
        end
        $display("test readback done");
        for (int n = 0; n < 300; n++) begin
            @(negedge i_clock);
            i_char_code = 8'($random(seed));
            if (n % 3 != 0) i_char_code[7:3] = 5'(n % 2 ? 1 : 0);
            i_row = 3'($random(seed));
            i_tall_font = n >= 270;
            i_cursor_here = !i_tall_font && 1'($random(seed));
            @(negedge i_clock);
            chk({3'h0, pix}, {3'h0, pix_exp(i_char_code, i_row,
                i_cursor_here, i_tall_font)});
            chk({7'h0, sel}, {7'h0, i_char_code < 8'h10});
        end
        $display("test display done");
        conclude();
    end
endmodule : test_custom_glyph_pattern_memory
`default_nettype wire
